// [rtl/smw_defines.vh]
// constants for the static memory wait-state controller
// Function
// (RULE1) sample wait input every clock during access
// (RULE2) bank select cycle counts as first wait
// (RULE3) recognise asserted wait within two clocks
// (RULE4) software programs at least two wait states
// (RULE5) wait phase lasts N clocks or wait-release, later
// (RULE6) two-state bank: wait asserted next cycle; with the synchroniser delay only banks of four or more states see it
// (RULE7) finish access three clocks after wait release
// (RULE8) wait count 2..31, assert delay bounded
// (RULE9) strobes active low, released at completion
// (RULE10) per-bank wait count applied to access
`ifndef SMW_DEFINES_VH
`define SMW_DEFINES_VH
`define SMW_WS_MIN     5'h02
`define SMW_WS_MAX     5'h1f
`define SMW_TAIL_CYC   2'h3
`define SMW_WS_RST     5'h1f
`define SMW_ST_IDLE    4'h1
`define SMW_ST_WAIT    4'h2
`define SMW_ST_TAIL    4'h4
`define SMW_ST_DONE    4'h8
`endif

// [rtl/smw_sync.v]
// two-flop synchroniser for one level input
module smw_sync (
	input  wire clock,
	input  wire rst_n,
	input  wire d_in,
	output wire q_out
);
	reg meta_ff;
	reg sync_ff;

	always @(posedge clock) begin
		if (!rst_n) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end else begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;
endmodule

// [rtl/smw_ctrl.v]
// static memory access sequencer with wait states and external wait input
`include "smw_defines.vh"
module smw_ctrl #(
	parameter NBANK = 4,
	parameter BW    = 2
) (
	input  wire             clock,
	input  wire             rst_n,
	input  wire             cfg_we,
	input  wire [BW-1:0]    cfg_bank,
	input  wire [4:0]       cfg_ws,
	input  wire             req_valid,
	input  wire             req_write,
	input  wire [BW-1:0]    req_bank,
	input  wire [1:0]       req_lanes,
	input  wire             ext_wait_n,
	output reg              req_ready,
	output reg              done_ff,
	output reg  [NBANK-1:0] bank_select_n,
	output reg              output_enable_n,
	output reg              write_enable_n,
	output reg  [1:0]       byte_lane_n
);
	reg  [3:0]  state_ff;
	reg  [3:0]  nxt_state;
	reg  [4:0]  cnt_ff;
	reg  [4:0]  nxt_cnt;
	reg  [1:0]  tail_ff;
	reg  [1:0]  nxt_tail;
	reg  [4:0]  ws_ff [0:NBANK-1];
	wire        wait_sync;
	wire [4:0]  ws_sel;
	wire [4:0]  cfg_ws_clamped;

	// pin input passes two flops before any logic sees it [RULE1] [RULE3]
	smw_sync u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d_in  (ext_wait_n),
		.q_out (wait_sync)
	);

	// counts below two cannot be stretched by wait, so clamp into range [RULE8]
	assign cfg_ws_clamped = (cfg_ws < `SMW_WS_MIN) ? `SMW_WS_MIN : cfg_ws;
	assign ws_sel = ws_ff[req_bank];

	genvar g;
	generate
		for (g = 0; g < NBANK; g = g + 1) begin : g_bank
			always @(posedge clock) begin
				if (!rst_n)
					ws_ff[g] <= `SMW_WS_RST;
				else if (cfg_we && cfg_bank == g) // [RULE10]
					ws_ff[g] <= cfg_ws_clamped;
			end
		end
	endgenerate

	always @* begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_tail  = tail_ff;
		case (state_ff)
			`SMW_ST_IDLE: begin
				if (req_valid) begin
					nxt_state = `SMW_ST_WAIT;
					// select cycle is wait state one [RULE2] [RULE10]
					nxt_cnt   = ws_sel - 5'h01;
				end
			end
			`SMW_ST_WAIT: begin
				if (cnt_ff != 5'h00)
					nxt_cnt = cnt_ff - 5'h01;
				// leave when count spent and wait seen released, later wins [RULE5]
				// wait phase spans at least n clocks including the select cycle
				if (cnt_ff == 5'h00 && wait_sync) begin
					nxt_state = `SMW_ST_TAIL;
					nxt_tail  = `SMW_TAIL_CYC;
				end
			end
			`SMW_ST_TAIL: begin
				if (tail_ff == 2'h1)
					nxt_state = `SMW_ST_DONE;
				else
					nxt_tail = tail_ff - 2'h1; // [RULE7]
			end
			`SMW_ST_DONE: nxt_state = `SMW_ST_IDLE;
			default: nxt_state = `SMW_ST_IDLE;
		endcase
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			state_ff        <= `SMW_ST_IDLE;
			cnt_ff          <= 5'h00;
			tail_ff         <= 2'h0;
			req_ready       <= 1'b1;
			done_ff         <= 1'b0;
			bank_select_n   <= {NBANK{1'b1}};
			output_enable_n <= 1'b1;
			write_enable_n  <= 1'b1;
			byte_lane_n     <= 2'h3;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			tail_ff  <= nxt_tail;
			done_ff  <= (state_ff == `SMW_ST_TAIL) && (nxt_state == `SMW_ST_DONE);
			req_ready <= (nxt_state == `SMW_ST_IDLE);
			if (state_ff == `SMW_ST_IDLE && req_valid) begin
				bank_select_n   <= ~({{(NBANK-1){1'b0}}, 1'b1} << req_bank); // [RULE9]
				output_enable_n <= req_write;
				write_enable_n  <= ~req_write;
				byte_lane_n     <= ~req_lanes;
			end else if (state_ff == `SMW_ST_TAIL && nxt_state == `SMW_ST_DONE) begin
				bank_select_n   <= {NBANK{1'b1}}; // [RULE9]
				output_enable_n <= 1'b1;
				write_enable_n  <= 1'b1;
				byte_lane_n     <= 2'h3;
			end
		end
	end
endmodule

// [tb/smw_props.sv]
// port checker for the wait-state controller
module smw_props(input wire clock, rst_n, req_valid, req_ready, done_ff, ext_wait_n,
	output_enable_n, write_enable_n, input wire [1:0] req_lanes, byte_lane_n,
	input wire [3:0] bank_select_n);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_go_low: assert property (req_valid && req_ready |=> !req_ready && ~&bank_select_n)
		else $error("no start");
	chk_done_free: assert property (done_ff |-> &{bank_select_n, output_enable_n, write_enable_n})
		else $error("held");
	chk_rw_excl: assert property (!output_enable_n |-> write_enable_n)
		else $error("both");
	chk_min_len: assert property ($fell(req_ready) |-> ~&bank_select_n [*5])
		else $error("short");
	chk_wait_tail: assert property ($rose(ext_wait_n) && !req_ready |-> ##[3:6] done_ff)
		else $error("tail");
	chk_ready_back: assert property (done_ff |=> req_ready)
		else $error("ready");
	chk_lane_map: assert property ($fell(req_ready) |-> byte_lane_n == ~$past(req_lanes))
		else $error("lanes");
	chk_one_bank: assert property ($onehot0(~bank_select_n))
		else $error("banks");
endmodule

// [tb/smw_mem_model.sv]
// far-side device that stretches accesses with its wait output
module smw_mem_model(input wire clock, input wire [3:0] bank_select_n,
	input wire [4:0] hold, output logic ext_wait_n = 1);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt_ff = 0;
	// low from the cycle after select; after the two-flop synchroniser only banks of four or more states see it
	always @(posedge clock) begin
		cnt_ff <= &bank_select_n ? 5'h0 : cnt_ff + 5'h1;
		ext_wait_n <= &bank_select_n || cnt_ff >= hold;
	end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the wait-state controller
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst_n = 0, cfg_we = 0, req_valid = 0, req_write = 0;
	logic [1:0] cfg_bank = 0, req_bank = 0, req_lanes = 0;
	logic [4:0] cfg_ws = 0, hold = 0;
	wire ext_wait_n, req_ready, done_ff, output_enable_n, write_enable_n;
	wire [3:0] bank_select_n;
	wire [1:0] byte_lane_n;
	int bad_count = 0, tests_run = 0, len;
	smw_ctrl u_smw_ctrl(.*);
	smw_mem_model u_smw_mem_model(.*);
	initial forever #12.5 clock = ~clock;
	task automatic chk(string n, int e, logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %0d got %0d", n, e, s);
		end
	endtask
	task automatic cfg(logic [1:0] b, logic [4:0] w);
		@(negedge clock) {cfg_we, cfg_bank, cfg_ws} = {1'b1, b, w};
		@(negedge clock) cfg_we = 0;
	endtask
	task automatic acc(logic w, logic [1:0] b, l);
		@(negedge clock) {req_valid, req_write, req_bank, req_lanes} = {1'b1, w, b, l};
		@(negedge clock) req_valid = 0;
		chk("lanes", 1, byte_lane_n === ~l && {write_enable_n, output_enable_n} === {~w, w});
		for (len = 0; bank_select_n !== 4'hf && len < 99; len++) @(negedge clock);
		chk("done", 1, done_ff);
		$display("access bank %0d took %0d", b, len);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#10us;
		bad_count++;
		tally_and_finish;
	end
	initial begin
		repeat (10) @(negedge clock);
		rst_n = 1;
		cfg(1, 2);
		cfg(2, 1);
		cfg(3, 4);
		acc(0, 1, 3);
		chk("len", 5, len);
		acc(1, 2, 1);
		chk("len", 5, len);
		acc(0, 0, 2);
		chk("len", 34, len);
		hold = 12;
		acc(1, 3, 2);
		chk("ext", 1, len > 15 && len < 22);
		tally_and_finish;
	end
endmodule
bind smw_ctrl smw_props u_smw_props(.*);
